// *** hdl/ctc_top.sv ***
/*
  Capture timer control: 32-bit free-running counter with run, clear and
  power controls, four capture channels with edge select, noise filter and
  filter clock select, APB register slave and one level interrupt.
  Assumes capture inputs are asynchronous pins and the bus runs on clk.
*/
//
// Function
// - Clear request stops counter, zeroes count
// - Clear bit self-clears when clear completes
// - Clear write keeps run; run cleared after
// - Run bit starts/stops counting, count kept
// - Counter resets zero, increments, wraps around
// - Count writable only while run is zero
// - Power bit zero stops counter, filters and capture; clear still runs
// - Three-bit filter clock select per channel
// - Bypass bit routes synchronised input past filter
// - Selected edge copies count into capture
// - Edge codes: fall, rise, both, disabled
// - Counter wrap raises timer interrupt event
`timescale 1ns/1ps

module ctc_top #(
  parameter int         NumChan     = 4,
  parameter int         FilterLen   = 3,
  parameter logic [7:0] FiltDiv [8] = '{8'h01, 8'h02, 8'h04, 8'h08,
                                        8'h10, 8'h20, 8'h40, 8'h80}
) (
  input  wire logic               clk,        // System clock, 25 MHz
  input  wire logic               reset,      // Synchronous reset, active high
  input  wire logic               psel,       // APB select
  input  wire logic               penable,    // APB enable
  input  wire logic               pwrite,     // APB direction
  input  wire logic [7:0]         paddr,      // APB byte address
  input  wire logic [31:0]        pwdata,     // APB write data
  output logic                    pready,     // APB ready
  output logic [31:0]             prdata,     // APB read data
  output logic                    pslverr,    // APB error on unmapped address
  input  wire logic [NumChan-1:0] captureIn,  // Capture input pins
  output logic                    irq,        // Level interrupt
  output logic                    wrapEvent   // Wrap pulse to aggregator
);

  if (NumChan < 1 || NumChan > 4) begin : gNumChanCheck
    $error("NumChan must be 1 to 4");
  end
  if (FilterLen < 2 || FilterLen > 8) begin : gFilterLenCheck
    $error("FilterLen must be 2 to 8");
  end

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  ctc_pkg::ctc_apb_req_t req;
  logic                  wrAcc;
  logic                  rdSetup;
  logic                  mapped;

  assign req    = '{psel, penable, pwrite, paddr, pwdata};
  assign pready = 1'b1;
  assign mapped = (req.addr == ctc_pkg::OFF_CONTROL)  || (req.addr == ctc_pkg::OFF_CAPCFG_LO) ||
                  (req.addr == ctc_pkg::OFF_COUNT)    || (req.addr == ctc_pkg::OFF_IRQ_STATUS) ||
                  (req.addr == ctc_pkg::OFF_IRQ_MASK) ||
                  (req.addr >= ctc_pkg::OFF_CAPTURE0 &&
                   req.addr <  ctc_pkg::OFF_CAPTURE0 + 8'(4 * NumChan) && req.addr[1:0] == 2'h0);
  assign pslverr = req.sel && req.enable && !mapped;
  assign wrAcc   = req.sel && req.enable && req.write && mapped;
  assign rdSetup = req.sel && !req.enable && !req.write;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [NumChan-1:0] syncA_r;
  logic [NumChan-1:0] syncB_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= captureIn;
      syncB_r <= syncA_r;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic                         power_r, power_nxt;
  logic                         run_r, run_nxt;
  logic                         clear_r, clear_nxt;
  ctc_pkg::ctc_clr_state_t      clrSt_r, clrSt_nxt;
  logic [31:0]                  cfg_r, cfg_nxt;
  logic [31:0]                  count_r, count_nxt;
  logic [NumChan:0]             status_r, status_nxt;
  logic [NumChan:0]             mask_r, mask_nxt;
  logic [31:0]                  cap_r [NumChan];
  logic [31:0]                  cap_nxt [NumChan];
  logic [NumChan-1:0]           filt_r, filt_nxt;
  logic [NumChan-1:0]           prev_r, prev_nxt;
  logic [FilterLen-1:0]         shift_r [NumChan];
  logic [FilterLen-1:0]         shift_nxt [NumChan];
  logic [7:0]                   div_r [NumChan];
  logic [7:0]                   div_nxt [NumChan];
  logic                         wrap_r, wrap_nxt;
  logic [31:0]                  rdata_r, rdata_nxt;

  ctc_pkg::ctc_chan_cfg_t       chCfg [NumChan];
  logic [NumChan-1:0]           chanIn;
  logic [NumChan-1:0]           capHit;
  logic                         wrapNow;

  // ==========================================================================
  // Channel filters and edge detection
  // ==========================================================================
  always_comb begin
    for (int n = 0; n < NumChan; n++) begin
      chCfg[n]     = cfg_r[n*ctc_pkg::CFG_CH_STRIDE +: ctc_pkg::CFG_CH_STRIDE];
      shift_nxt[n] = shift_r[n];
      div_nxt[n]   = div_r[n];
      filt_nxt[n]  = filt_r[n];
      if (power_r) begin
        if (div_r[n] >= FiltDiv[chCfg[n].filterClock] - 8'h01) begin
          div_nxt[n]   = 8'h00;
          shift_nxt[n] = {shift_r[n][FilterLen-2:0], syncB_r[n]};
          if (&shift_nxt[n])
            filt_nxt[n] = 1'b1;
          else if (~|shift_nxt[n])
            filt_nxt[n] = 1'b0;
        end else begin
          div_nxt[n] = div_r[n] + 8'h01;
        end
      end
      chanIn[n]   = chCfg[n].filterSkip ? syncB_r[n] : filt_r[n];
      prev_nxt[n] = chanIn[n];
      case (chCfg[n].trigEdge)
        ctc_pkg::EDGE_FALL: capHit[n] = prev_r[n] && !chanIn[n];
        ctc_pkg::EDGE_RISE: capHit[n] = !prev_r[n] && chanIn[n];
        ctc_pkg::EDGE_BOTH: capHit[n] = prev_r[n] != chanIn[n];
        default:            capHit[n] = 1'b0;
      endcase
      capHit[n]  = capHit[n] && power_r;
      cap_nxt[n] = capHit[n] ? count_r : cap_r[n];
    end
  end

  // ==========================================================================
  // Control, counter and interrupt next state
  // ==========================================================================
  always_comb begin
    power_nxt  = power_r;
    run_nxt    = run_r;
    clear_nxt  = clear_r;
    clrSt_nxt  = clrSt_r;
    cfg_nxt    = cfg_r;
    count_nxt  = count_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    wrapNow    = 1'b0;

    if (wrAcc && req.addr == ctc_pkg::OFF_CONTROL) begin
      power_nxt = req.wdata[ctc_pkg::CTL_POWER_BIT];
      if (req.wdata[ctc_pkg::CTL_CLEAR_BIT])
        clear_nxt = 1'b1;
      else
        run_nxt = req.wdata[ctc_pkg::CTL_RUN_BIT];
    end
    if (wrAcc && req.addr == ctc_pkg::OFF_CAPCFG_LO)
      cfg_nxt = req.wdata;
    if (wrAcc && req.addr == ctc_pkg::OFF_IRQ_MASK)
      mask_nxt = req.wdata[NumChan:0];

    case (clrSt_r)
      ctc_pkg::CLR_IDLE: if (clear_r) clrSt_nxt = ctc_pkg::CLR_BUSY;
      ctc_pkg::CLR_BUSY: begin
        count_nxt = ctc_pkg::RST_COUNT;
        clrSt_nxt = ctc_pkg::CLR_DONE;
      end
      ctc_pkg::CLR_DONE: begin
        clear_nxt = 1'b0;
        run_nxt   = 1'b0;
        clrSt_nxt = ctc_pkg::CLR_IDLE;
      end
      default: clrSt_nxt = ctc_pkg::CLR_IDLE;
    endcase

    if (clrSt_r == ctc_pkg::CLR_IDLE && !clear_r && power_r) begin
      if (run_r) begin
        count_nxt = count_r + 32'h0000_0001;
        wrapNow   = (count_r == ctc_pkg::COUNT_MAX);
      end else if (wrAcc && req.addr == ctc_pkg::OFF_COUNT) begin
        count_nxt = req.wdata;
      end
    end

    if (wrAcc && req.addr == ctc_pkg::OFF_IRQ_STATUS)
      status_nxt = status_r & ~req.wdata[NumChan:0];
    if (wrapNow)
      status_nxt[ctc_pkg::IRQ_WRAP_BIT] = 1'b1;
    for (int n = 0; n < NumChan; n++)
      if (capHit[n])
        status_nxt[ctc_pkg::IRQ_CAP_BIT + n] = 1'b1;
    wrap_nxt = wrapNow;
  end

  // ==========================================================================
  // Read mux
  // ==========================================================================
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rdSetup) begin
      case (req.addr)
        ctc_pkg::OFF_CONTROL:    rdata_nxt = {29'h0, clear_r, run_r, power_r};
        ctc_pkg::OFF_CAPCFG_LO:  rdata_nxt = cfg_r;
        ctc_pkg::OFF_COUNT:      rdata_nxt = count_r;
        ctc_pkg::OFF_IRQ_STATUS: rdata_nxt = 32'(status_r);
        ctc_pkg::OFF_IRQ_MASK:   rdata_nxt = 32'(mask_r);
        default: begin
          for (int n = 0; n < NumChan; n++)
            if (req.addr == ctc_pkg::OFF_CAPTURE0 + 8'(4 * n))
              rdata_nxt = cap_r[n];
        end
      endcase
    end
  end

  // Read data is latched in the setup cycle and held through the access phase
  assign prdata    = rdata_r;
  assign irq       = |(status_r & mask_r);
  assign wrapEvent = wrap_r;

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      power_r  <= ctc_pkg::RST_CONTROL[ctc_pkg::CTL_POWER_BIT];
      run_r    <= ctc_pkg::RST_CONTROL[ctc_pkg::CTL_RUN_BIT];
      clear_r  <= ctc_pkg::RST_CONTROL[ctc_pkg::CTL_CLEAR_BIT];
      clrSt_r  <= ctc_pkg::CLR_IDLE;
      cfg_r    <= ctc_pkg::RST_CAPCFG;
      count_r  <= ctc_pkg::RST_COUNT;
      status_r <= '0;
      mask_r   <= '0;
      filt_r   <= '0;
      prev_r   <= '0;
      wrap_r   <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      for (int n = 0; n < NumChan; n++) begin
        cap_r[n]   <= 32'h0000_0000;
        shift_r[n] <= '0;
        div_r[n]   <= 8'h00;
      end
    end else begin
      power_r  <= power_nxt;
      run_r    <= run_nxt;
      clear_r  <= clear_nxt;
      clrSt_r  <= clrSt_nxt;
      cfg_r    <= cfg_nxt;
      count_r  <= count_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      filt_r   <= filt_nxt;
      prev_r   <= prev_nxt;
      wrap_r   <= wrap_nxt;
      rdata_r  <= rdata_nxt;
      for (int n = 0; n < NumChan; n++) begin
        cap_r[n]   <= cap_nxt[n];
        shift_r[n] <= shift_nxt[n];
        div_r[n]   <= div_nxt[n];
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  clear_zero_a: assert property (@(posedge clk) disable iff (reset)
    clrSt_r == ctc_pkg::CLR_BUSY |=> count_r == 32'h0000_0000)
    else $error("count not zero after clear");
  clear_self_a: assert property (@(posedge clk) disable iff (reset)
    $rose(clear_r) |-> ##[1:3] !clear_r)
    else $error("clear bit did not self-clear");
  clear_run_a: assert property (@(posedge clk) disable iff (reset)
    $fell(clear_r) |-> !run_r)
    else $error("run still set after clear");
  run_hold_a: assert property (@(posedge clk) disable iff (reset)
    !run_r && clrSt_r == ctc_pkg::CLR_IDLE && !wrAcc |=> $stable(count_r))
    else $error("stopped counter moved");
  count_inc_a: assert property (@(posedge clk) disable iff (reset)
    run_r && power_r && !clear_r && clrSt_r == ctc_pkg::CLR_IDLE
    |=> count_r == $past(count_r) + 32'h0000_0001)
    else $error("counter did not increment");
  count_lock_a: assert property (@(posedge clk) disable iff (reset)
    run_r && wrAcc && req.addr == ctc_pkg::OFF_COUNT && clrSt_r == ctc_pkg::CLR_IDLE
    && !clear_r && power_r |=> count_r == $past(count_r) + 32'h0000_0001)
    else $error("count written while running");
  power_gate_a: assert property (@(posedge clk) disable iff (reset)
    !power_r && !wrAcc |=> $stable(count_r) && $stable(status_r[NumChan:1]))
    else $error("activity while unpowered");
  capture_copy_a: assert property (@(posedge clk) disable iff (reset)
    capHit[0] |=> cap_r[0] == $past(count_r))
    else $error("capture missed count");
  edge_off_a: assert property (@(posedge clk) disable iff (reset)
    chCfg[0].trigEdge == ctc_pkg::EDGE_OFF |-> !capHit[0])
    else $error("capture while disabled");
  wrap_irq_a: assert property (@(posedge clk) disable iff (reset)
    wrapNow |=> wrapEvent && status_r[0] && count_r == 32'h0000_0000)
    else $error("wrap event missing");

endmodule : ctc_top

// *** inc/ctc_pkg.sv ***
/*
  Package for the capture timer control block: register offsets, field
  positions, reset values and shared types.
  Assumes a 32-bit APB register bus and a single 25 MHz system clock.
*/
package ctc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_CAPCFG_LO  = 8'h04;
  localparam logic [7:0] OFF_COUNT      = 8'h0C;
  localparam logic [7:0] OFF_CAPTURE0   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h44;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTL_POWER_BIT = 0;
  localparam int CTL_RUN_BIT   = 1;
  localparam int CTL_CLEAR_BIT = 2;

  // ==========================================================================
  // Capture configuration fields (channel n at base 8*n)
  // ==========================================================================
  localparam int CFG_EDGE_POS  = 0;
  localparam int CFG_SKIP_POS  = 2;
  localparam int CFG_FCLK_POS  = 5;
  localparam int CFG_CH_STRIDE = 8;

  // ==========================================================================
  // Interrupt status bits
  // ==========================================================================
  localparam int IRQ_WRAP_BIT = 0;
  localparam int IRQ_CAP_BIT  = 1;   // Channel n capture at bit 1+n

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_CAPCFG  = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT   = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX   = 32'hFFFF_FFFF;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_OFF  = 2'h3
  } ctc_edge_t;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'h0,
    CLR_BUSY = 2'h1,
    CLR_DONE = 2'h3
  } ctc_clr_state_t;

  typedef struct packed {
    logic       sel;
    logic       enable;
    logic       write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ctc_apb_req_t;

  typedef struct packed {
    logic [2:0] filterClock;
    logic [1:0] spare;
    logic       filterSkip;
    ctc_edge_t  trigEdge;
  } ctc_chan_cfg_t;

endpackage : ctc_pkg

// *** verif/ctc_pin_model.sv ***
/*
  Capture pin model: drives the four capture inputs at the levels the
  bench requests. Assumes pinReq changes just after a rising clk edge.
*/
`timescale 1ns/1ps

module ctc_pin_model (
  input  wire logic       clk,       // System clock
  input  wire logic [3:0] pinReq,    // Requested pin levels
  output logic      [3:0] captureIn  // Pins toward the block
);
  // ==========================================================================
  // Pin drive
  // ==========================================================================
  always @(posedge clk) begin
    captureIn <= pinReq;
  end
endmodule : ctc_pin_model

// *** verif/testbench.sv ***
/*
  Testbench for the capture timer control block: APB access tasks and
  directed checks of counter, clear, power, interrupt and capture edges.
  Assumes the pin model drives the capture inputs; no checker file.
*/
`timescale 1ns/1ps

module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [3:0]  pinReq = 4'h0;
  logic [3:0]  captureIn;
  logic        irq;
  logic        wrapEvent;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  ctc_top #(.NumChan(4), .FilterLen(3)) dut (
    .clk      (clk),
    .reset    (reset),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .captureIn(captureIn),
    .irq      (irq),
    .wrapEvent(wrapEvent)
  );

  ctc_pin_model pins (
    .clk      (clk),
    .pinReq   (pinReq),
    .captureIn(captureIn)
  );

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Setup cycle, access until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is looked at mid-cycle, where it is settled for the next edge
    @(negedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      @(negedge clk);
    end
    rdv = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, exp, d);
  endtask : rchk

  // ==========================================================================
  // Timeout
  // ==========================================================================
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] v;
    logic        e;
    int          n;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk("control", ctc_pkg::OFF_CONTROL, 32'h0000_0000);
    rchk("capcfg", ctc_pkg::OFF_CAPCFG_LO, 32'h0000_0000);
    rchk("count", ctc_pkg::OFF_COUNT, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ctc_pkg::OFF_CAPCFG_LO, 32'hE7A5_C6E4);
    rchk("capcfg", ctc_pkg::OFF_CAPCFG_LO, 32'hE7A5_C6E4);
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0001);
    wr(ctc_pkg::OFF_COUNT, 32'h1234_5678);
    rchk("count load", ctc_pkg::OFF_COUNT, 32'h1234_5678);
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0003);
    wr(ctc_pkg::OFF_COUNT, 32'h0000_0000);
    rd(ctc_pkg::OFF_COUNT, a);
    chk("count runs on", 32'h1, {31'h0, a > 32'h1234_5678});
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0001);
    rd(ctc_pkg::OFF_COUNT, a);
    rd(ctc_pkg::OFF_COUNT, b);
    chk("count stopped", a, b);
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0002);
    rd(ctc_pkg::OFF_COUNT, v);
    chk("count unpowered", b, v);
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0001);
    wr(ctc_pkg::OFF_COUNT, 32'hFFFF_FFF0);
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0003);
    n = 0;
    @(negedge clk);
    while (wrapEvent !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("wrap pulse", 32'h1, {31'h0, wrapEvent});
    @(posedge clk);
    rchk("irq status", ctc_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ctc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(ctc_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0005);
    n = 0;
    do begin
      rd(ctc_pkg::OFF_CONTROL, v);
      n++;
    end while (v[2] !== 1'b0 && n < 20);
    chk("control after clear", 32'h0000_0001, v);
    rchk("count cleared", ctc_pkg::OFF_COUNT, 32'h0000_0000);
    wr(ctc_pkg::OFF_CONTROL, 32'h0000_0003);
    for (int ch = 0; ch < 4; ch++) begin
      for (int code = 0; code < 4; code++) begin
        wr(ctc_pkg::OFF_CAPCFG_LO, (32'h0000_0004 | code) << (8 * ch));
        wr(ctc_pkg::OFF_IRQ_STATUS, 32'hFFFF_FFFF);
        rd(ctc_pkg::OFF_COUNT, a);
        pinReq[ch] <= 1'b1;
        repeat (12) @(posedge clk);
        rd(ctc_pkg::OFF_CAPTURE0 + 8'(4 * ch), v);
        rd(ctc_pkg::OFF_COUNT, b);
        if (code == 1 || code == 2) begin
          chk("capture value", 32'h1, {31'h0, v > a && v < b});
        end
        rd(ctc_pkg::OFF_IRQ_STATUS, v);
        chk("rise flag", 32'(code == 1 || code == 2), 32'(v[1 + ch]));
        wr(ctc_pkg::OFF_IRQ_STATUS, 32'hFFFF_FFFF);
        pinReq[ch] <= 1'b0;
        repeat (12) @(posedge clk);
        rd(ctc_pkg::OFF_IRQ_STATUS, v);
        chk("fall flag", 32'(code == 0 || code == 2), 32'(v[1 + ch]));
      end
    end
    for (int skip = 0; skip < 2; skip++) begin
      wr(ctc_pkg::OFF_CAPCFG_LO, 32'h0000_0002 | 32'(skip << 2));
      wr(ctc_pkg::OFF_IRQ_STATUS, 32'hFFFF_FFFF);
      pinReq[0] <= 1'b1;
      @(posedge clk);
      pinReq[0] <= 1'b0;
      repeat (12) @(posedge clk);
      rd(ctc_pkg::OFF_IRQ_STATUS, v);
      chk("glitch flag", 32'(skip), 32'(v[1]));
    end
    for (int fc = 0; fc < 2; fc++) begin
      wr(ctc_pkg::OFF_CAPCFG_LO, 32'h0000_0002 | 32'(fc << 5));
      wr(ctc_pkg::OFF_IRQ_STATUS, 32'hFFFF_FFFF);
      pinReq[0] <= 1'b1;
      repeat (4) @(posedge clk);
      pinReq[0] <= 1'b0;
      repeat (16) @(posedge clk);
      rd(ctc_pkg::OFF_IRQ_STATUS, v);
      chk("filter clock flag", 32'(fc == 0), 32'(v[1]));
    end
    apb(1'b0, 8'h30, 32'h0000_0000, v, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, v);
    print_verdict();
  end
endmodule : testbench
